// *** verilog/status_mask_pkg.sv ***
// Package: register map, field positions and reset values of the bank
package status_mask_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_STEP_UP_HEALTH = 8'h27;
    localparam logic [7:0] ADDR_DIAG_INPUT_HEALTH = 8'h28;
    localparam logic [7:0] ADDR_TOP_EVENT_MASK_A = 8'h29;
    localparam logic [7:0] ADDR_TOP_EVENT_MASK_B = 8'h2a;
    localparam logic [7:0] ADDR_STEP_DOWN_EVENT_MASK = 8'h2b;
    localparam logic [7:0] ADDR_TOP_STATUS = 8'h25;
    // Step-up health fields
    localparam int STEP_UP_ON_BIT = 3;
    localparam int STEP_UP_GOOD_BIT = 2;
    localparam int STEP_UP_LIMIT_BIT = 0;
    // Diagnostic input health fields
    localparam int MONITOR_B_GOOD_BIT = 4;
    localparam int MONITOR_A_GOOD_BIT = 2;
    localparam int ANALOG_SUPPLY_GOOD_BIT = 0;
    // Top status field
    localparam int THERMAL_WARN_BIT = 1;
    // Mask A fields
    localparam int LOAD_MEAS_READY_MASK_BIT = 7;
    localparam int EXT_CLK_MASK_BIT = 3;
    localparam int THERMAL_WARN_MASK_BIT = 1;
    // Mask B field
    localparam int REG_RESET_MASK_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_MASK_A = 8'h00;
    localparam logic [7:0] RST_MASK_B = 8'h01;
    localparam logic [7:0] RST_MASK_STEP_DOWN = 8'h00;
    // Writable bits of each mask
    localparam logic [7:0] USED_MASK_A = 8'h8a;
    localparam logic [7:0] USED_MASK_B = 8'h01;
    localparam logic [7:0] USED_MASK_STEP_DOWN = 8'hff;
    // Bus read fetch states
    typedef enum logic [0:0] {
        LOAD_IDLE = 1'b0,
        LOAD_DONE = 1'b1
    } load_state_type;
endpackage

// *** verilog/mask_reg.sv ***
// One writable mask register with a programmable-memory default
`timescale 1ns/1ps
module mask_reg
    import status_mask_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] USED_BITS = 8'hff
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Default load from programmable memory
    input wire logic i_load,
    input wire logic [7:0] i_default,
    // Software write
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    // Stored value
    output logic [7:0] o_value
);
    logic [7:0] value_r;
    logic [7:0] value_nxt;

    // Default load takes part over a write in the same cycle
    assign value_nxt = i_load ? (i_default & USED_BITS) :
                       i_wr ? (i_wdata & USED_BITS) : value_r;

    // Mask storage, constant under reset
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            value_r <= RESET_VALUE;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign o_value = value_r;
endmodule

// *** verilog/event_gate.sv ***
// Gates raw events by their mask bits into interrupt requests
`timescale 1ns/1ps
module event_gate #(
    parameter int WIDTH = 4
) (
    // Raw events and their masks
    input wire logic [WIDTH-1:0] i_event,
    input wire logic [WIDTH-1:0] i_mask,
    // Requests toward the flag registers
    output logic [WIDTH-1:0] o_request
);
    // A mask of one suppresses, zero lets the event through
    assign o_request = i_event & ~i_mask;
endmodule

// *** verilog/status_and_event_mask_bank.sv ***
// Status and event mask register bank of the power manager
// Operation
// - Step-up on state reads at bit 3
// - Step-up output good reads at bit 2
// - Step-up current limit reads at bit 0
// - Monitor input b good at bit 4
// - Monitor input a good at bit 2
// - Analog supply good at bit 0
// - Mask A bit 7 gates measurement ready
// - Mask A bit 3 gates clock detection
// - Mask A bit 1 gates thermal warning
// - Thermal mask never alters thermal status
// - Mask B bit 0 gates register reset
// - Mask B resets to 01h
// - Mask defaults load from programmable memory
// - Diagnostic status at 28h, reserved zero
// - Mask A at 29h resets to 00h
// - Thermal warning status at top bit 1
`timescale 1ns/1ps
module status_and_event_mask_bank
    import status_mask_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Programmable memory defaults, applied on i_otp_load
    input wire logic i_otp_load,
    input wire logic [7:0] i_otp_mask_a,
    input wire logic [7:0] i_otp_mask_b,
    input wire logic [7:0] i_otp_mask_step_down,
    // Raw step-up converter conditions
    input wire logic i_step_up_on,
    input wire logic i_step_up_good,
    input wire logic i_step_up_limit,
    // Raw monitor conditions
    input wire logic i_monitor_b_good,
    input wire logic i_monitor_a_good,
    input wire logic i_analog_supply_good,
    // Raw thermal warning level
    input wire logic i_thermal_warn,
    // Raw events for the outside flag logic
    input wire logic i_load_meas_ready_evt,
    input wire logic i_ext_clk_evt,
    input wire logic i_thermal_warn_evt,
    input wire logic i_reg_reset_evt,
    // Unmasked event requests
    output logic o_load_meas_ready_irq,
    output logic o_ext_clk_irq,
    output logic o_thermal_warn_irq,
    output logic o_reg_reset_irq,
    // Mask values for the step-down and flag logic
    output logic [7:0] o_step_down_event_mask,
    // Current mask A and B values
    output logic [7:0] o_top_event_mask_a,
    output logic [7:0] o_top_event_mask_b
);
    logic [7:0] step_up_health;
    logic [7:0] diag_input_health;
    logic [7:0] top_status;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] mask_sd;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [3:0] events;
    logic [3:0] masks;
    logic [3:0] requests;
    logic wr_mask_a;
    logic wr_mask_b;
    logic wr_mask_sd;

    // Raw status words; unlisted bits stay zero
    always_comb begin
        step_up_health = RST_STATUS;
        step_up_health[STEP_UP_ON_BIT] = i_step_up_on;
        step_up_health[STEP_UP_GOOD_BIT] = i_step_up_good;
        step_up_health[STEP_UP_LIMIT_BIT] = i_step_up_limit;
    end

    // Diagnostic word is combinational; only the read data register samples it
    always_comb begin
        diag_input_health = RST_STATUS;
        diag_input_health[MONITOR_B_GOOD_BIT] = i_monitor_b_good;
        diag_input_health[MONITOR_A_GOOD_BIT] = i_monitor_a_good;
        diag_input_health[ANALOG_SUPPLY_GOOD_BIT] =
            i_analog_supply_good;
    end

    // Thermal flag taken straight from the input, mask not involved
    always_comb begin
        top_status = RST_STATUS;
        top_status[THERMAL_WARN_BIT] = i_thermal_warn;
    end

    // Write decode; status offsets have no write path at all
    assign wr_mask_a = i_wr && (i_addr == ADDR_TOP_EVENT_MASK_A);
    assign wr_mask_b = i_wr && (i_addr == ADDR_TOP_EVENT_MASK_B);
    assign wr_mask_sd = i_wr && (i_addr == ADDR_STEP_DOWN_EVENT_MASK);

    // Mask A at 29h
    mask_reg #(
        .RESET_VALUE(RST_MASK_A),
        .USED_BITS(USED_MASK_A)
    ) u_mask_a (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_load(i_otp_load),
        .i_default(i_otp_mask_a),
        .i_wr(wr_mask_a),
        .i_wdata(i_wdata),
        .o_value(mask_a)
    );

    // Mask B at 2ah
    mask_reg #(
        .RESET_VALUE(RST_MASK_B),
        .USED_BITS(USED_MASK_B)
    ) u_mask_b (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_load(i_otp_load),
        .i_default(i_otp_mask_b),
        .i_wr(wr_mask_b),
        .i_wdata(i_wdata),
        .o_value(mask_b)
    );

    // Step-down mask at 2bh, stored only; its layout is used elsewhere
    mask_reg #(
        .RESET_VALUE(RST_MASK_STEP_DOWN),
        .USED_BITS(USED_MASK_STEP_DOWN)
    ) u_mask_sd (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_load(i_otp_load),
        .i_default(i_otp_mask_step_down),
        .i_wr(wr_mask_sd),
        .i_wdata(i_wdata),
        .o_value(mask_sd)
    );

    // Pair each event with its mask bit
    assign events = {i_load_meas_ready_evt, i_ext_clk_evt,
                     i_thermal_warn_evt, i_reg_reset_evt};
    assign masks = {mask_a[LOAD_MEAS_READY_MASK_BIT],
                    mask_a[EXT_CLK_MASK_BIT],
                    mask_a[THERMAL_WARN_MASK_BIT],
                    mask_b[REG_RESET_MASK_BIT]};

    event_gate #(
        .WIDTH(4)
    ) u_gate (
        .i_event(events),
        .i_mask(masks),
        .o_request(requests)
    );

    assign o_load_meas_ready_irq = requests[3];
    assign o_ext_clk_irq = requests[2];
    assign o_thermal_warn_irq = requests[1];
    assign o_reg_reset_irq = requests[0];

    // Read select; unmapped offsets read zero
    always_comb begin
        unique case (i_addr)
            ADDR_TOP_STATUS: rdata_nxt = top_status;
            ADDR_STEP_UP_HEALTH: rdata_nxt = step_up_health;
            ADDR_DIAG_INPUT_HEALTH: rdata_nxt = diag_input_health;
            ADDR_TOP_EVENT_MASK_A: rdata_nxt = mask_a;
            ADDR_TOP_EVENT_MASK_B: rdata_nxt = mask_b;
            ADDR_STEP_DOWN_EVENT_MASK: rdata_nxt = mask_sd;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= i_rd ? rdata_nxt : 8'h00;
        end
    end

    assign o_rdata = rdata_r;
    assign o_step_down_event_mask = mask_sd;
    assign o_top_event_mask_a = mask_a;
    assign o_top_event_mask_b = mask_b;
endmodule

// *** sim/status_mask_checker.sv ***
// Port-level checker of the status and event mask bank
`timescale 1ns/1ps
module status_mask_checker (
    // Clock, reset and register port
    input wire logic i_core_clk, i_reset, i_wr, i_rd, i_otp_load,
    input wire logic [7:0] i_addr, i_wdata, o_rdata, i_otp_mask_a,
    // Events, requests and masks
    input wire logic i_load_meas_ready_evt, i_ext_clk_evt,
    input wire logic i_reg_reset_evt, o_load_meas_ready_irq,
    input wire logic o_ext_clk_irq, o_reg_reset_irq,
    input wire logic [7:0] o_top_event_mask_a, o_top_event_mask_b
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Requests follow event and mask within the same cycle
    a_meas_irq_gate: assert property (o_load_meas_ready_irq ==
        (i_load_meas_ready_evt && !o_top_event_mask_a[7]))
        else $error("measurement request gating wrong");
    a_clk_irq_gate: assert property (o_ext_clk_irq ==
        (i_ext_clk_evt && !o_top_event_mask_a[3]))
        else $error("clock detect request gating wrong");
    a_reg_irq_gate: assert property (o_reg_reset_irq ==
        (i_reg_reset_evt && !o_top_event_mask_b[0]))
        else $error("register reset request gating wrong");
    // Writes land one cycle later, reserved bits dropped
    a_mask_a_write: assert property (
        i_wr && i_addr == 8'h29 && !i_otp_load |=>
        o_top_event_mask_a == ($past(i_wdata) & 8'h8a))
        else $error("mask a write wrong");
    a_mask_b_write: assert property (
        i_wr && i_addr == 8'h2a && !i_otp_load |=>
        o_top_event_mask_b == ($past(i_wdata) & 8'h01))
        else $error("mask b write wrong");
    a_otp_default: assert property (
        i_otp_load |=> o_top_event_mask_a == ($past(i_otp_mask_a) & 8'h8a))
        else $error("default load of mask a wrong");
    // Other addresses never disturb mask a
    a_mask_a_hold: assert property (
        !(i_wr && i_addr == 8'h29) && !i_otp_load |=>
        $stable(o_top_event_mask_a))
        else $error("mask a changed without write");
    a_diag_reserved: assert property (
        i_rd && i_addr == 8'h28 |=> (o_rdata & 8'hea) == 8'h00)
        else $error("diagnostic reserved bits not zero");
endmodule

bind status_and_event_mask_bank status_mask_checker i_chk (.*);

// *** sim/tb.sv ***
// Self-checking bench for the status and event mask bank
`timescale 1ns/1ps
module tb;
    logic i_core_clk = 1'h0, i_reset = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
    logic i_otp_load = 1'h0, i_step_up_on = 1'h0, i_step_up_good = 1'h0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [7:0] i_otp_mask_a = 8'h00, i_otp_mask_b = 8'h00;
    logic [7:0] i_otp_mask_step_down = 8'h00;
    logic i_step_up_limit = 1'h0, i_monitor_b_good = 1'h0;
    logic i_monitor_a_good = 1'h0, i_analog_supply_good = 1'h0;
    logic i_thermal_warn = 1'h0, i_load_meas_ready_evt = 1'h0;
    logic i_ext_clk_evt = 1'h0, i_thermal_warn_evt = 1'h0;
    logic i_reg_reset_evt = 1'h0, o_load_meas_ready_irq, o_ext_clk_irq;
    logic o_thermal_warn_irq, o_reg_reset_irq;
    logic [7:0] o_step_down_event_mask, o_top_event_mask_a;
    logic [7:0] o_top_event_mask_b;
    int fails = 0;
    int tests_run = 0;

    status_and_event_mask_bank i_dut (.*);

    // Clock of 100 ns
    always #50 i_core_clk = ~i_core_clk;

    task automatic chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bus cycles: one-cycle strobes, read data in the next cycle
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_core_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'h0;
        #1;
    endtask

    task automatic rchk(input string n, input logic [7:0] a, e);
        @(posedge i_core_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        #1 chk(n, e, o_rdata);
    endtask

    function automatic logic [7:0] irqs();
        return {4'h0, o_load_meas_ready_irq, o_ext_clk_irq,
            o_thermal_warn_irq, o_reg_reset_irq};
    endfunction

    task automatic t_reset;
        rchk("diag", 8'h28, 8'h00);
        rchk("mask_a", 8'h29, 8'h00);
        rchk("mask_b", 8'h2a, 8'h01);
        $display("reset test done");
    endtask

    // Raw levels show unlatched at their bit positions
    task automatic t_status;
        @(posedge i_core_clk);
        {i_step_up_on, i_step_up_good, i_step_up_limit} <= 3'h5;
        {i_monitor_b_good, i_monitor_a_good, i_analog_supply_good} <= 3'h6;
        rchk("step_up", 8'h27, 8'h09);
        rchk("diag", 8'h28, 8'h14);
        @(posedge i_core_clk);
        {i_step_up_on, i_step_up_good, i_step_up_limit} <= 3'h2;
        {i_monitor_b_good, i_monitor_a_good, i_analog_supply_good} <= 3'h1;
        rchk("step_up", 8'h27, 8'h04);
        rchk("diag", 8'h28, 8'h01);
        $display("status test done");
    endtask

    // Every mask bit set, then all but mask A bit 3 cleared, with all events high
    task automatic t_gate;
        @(posedge i_core_clk);
        {i_load_meas_ready_evt, i_ext_clk_evt} <= 2'h3;
        {i_thermal_warn_evt, i_reg_reset_evt, i_thermal_warn} <= 3'h7;
        wr(8'h29, 8'hff);
        wr(8'h2a, 8'hff);
        chk("irqs", 8'h00, irqs());
        chk("mask_b", 8'h01, o_top_event_mask_b);
        rchk("mask_a", 8'h29, 8'h8a);
        rchk("top", 8'h25, 8'h02);
        wr(8'h29, 8'h08);
        wr(8'h2a, 8'h00);
        chk("irqs", 8'h0b, irqs());
        rchk("top", 8'h25, 8'h02);
        wr(8'h2b, 8'h5a);
        chk("step_down", 8'h5a, o_step_down_event_mask);
        $display("gate test done");
    endtask

    // Writes to status and unmapped places change nothing
    task automatic t_ro;
        wr(8'h27, 8'hff);
        wr(8'h28, 8'hfe);
        wr(8'h25, 8'h00);
        wr(8'h30, 8'hff);
        rchk("step_up", 8'h27, 8'h04);
        rchk("diag", 8'h28, 8'h01);
        rchk("top", 8'h25, 8'h02);
        rchk("unmapped", 8'h30, 8'h00);
        chk("mask_a", 8'h08, o_top_event_mask_a);
        $display("read-only test done");
    endtask

    // Default load with a same-cycle write that masks to the same value, software then overwrites
    task automatic t_otp;
        @(posedge i_core_clk);
        i_otp_mask_a <= 8'hff;
        i_otp_mask_step_down <= 8'h3c;
        i_otp_load <= 1'h1;
        i_wr <= 1'h1;
        i_addr <= 8'h29;
        @(posedge i_core_clk);
        i_otp_load <= 1'h0;
        i_wr <= 1'h0;
        #1 chk("mask_a", 8'h8a, o_top_event_mask_a);
        chk("mask_b", 8'h00, o_top_event_mask_b);
        chk("step_down", 8'h3c, o_step_down_event_mask);
        wr(8'h29, 8'h80);
        chk("mask_a", 8'h80, o_top_event_mask_a);
        @(posedge i_core_clk);
        i_reset <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        i_reset <= 1'h0;
        rchk("mask_b", 8'h2a, 8'h01);
        rchk("mask_a", 8'h29, 8'h00);
        $display("default load test done");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog at 2000 cycles, well past the 65 or so cycles the tests need
    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge i_core_clk);
        i_reset <= 1'h0;
        t_reset();
        t_status();
        t_gate();
        t_ro();
        t_otp();
        test_done();
    end
endmodule
